// *** logic/acr_pkg.sv ***
// Constants, types and field layout for the calibration configuration
// register bank (register page 2, four lowest addresses).
// Assumes a single 10 MHz clock and an APB master with 32-bit data.
// Summary of operation
// - Bypass bit set drops digital offset correction
// - Mode field selects black, binary white, fine
// - Calibration lasts programmed lines; 255 means forever
// - Digital offset step scaled 1, 1/2, 1/4, 1/8
// - Analog offset step scaled 1/2, 1/4, 1/8
// - Black loop averages 4, 8, 16 or 32 pixels
// - Black target is 11-bit, 16-bit value times 32
`default_nettype none

package acr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CAL_MODE    = 5'h00;
  localparam logic [4:0] IDX_LINE_COUNT  = 5'h01;
  localparam logic [4:0] IDX_BLACK_CFG   = 5'h02;
  localparam logic [4:0] IDX_BLACK_TGT   = 5'h03;
  localparam logic [4:0] IDX_CAL_STATUS  = 5'h1E;
  localparam logic [4:0] IDX_PAGE_SEL    = 5'h1F;

  // Page that holds the calibration registers
  localparam logic [3:0] CAL_PAGE        = 4'h2;

  // Reset values
  localparam logic [7:0] RST_CAL_MODE    = 8'h00;
  localparam logic [7:0] RST_LINE_COUNT  = 8'h00;
  localparam logic [7:0] RST_BLACK_CFG   = 8'h14;
  localparam logic [7:0] RST_BLACK_TGT   = 8'h40;
  localparam logic [3:0] RST_PAGE_SEL    = 4'h0;

  // Field positions
  localparam int BYPASS_BIT  = 2;
  localparam int MODE_LSB    = 0;
  localparam int DSTEP_LSB   = 4;
  localparam int ASTEP_LSB   = 2;
  localparam int NPIX_LSB    = 0;

  // Line count encodings
  localparam logic [7:0] LINES_FOREVER   = 8'hFF;
  localparam logic [7:0] LINES_RESERVED  = 8'h00;

  // 11-bit target to 16-bit output scale
  localparam int TARGET_SHIFT = 5;
  // Smallest averaging window of the black loop
  localparam logic [5:0] PIX_BASE        = 6'h04;

  // Calibration mode codes, in field order
  typedef enum logic [1:0] {
    ACR_BLACK_ONLY,
    ACR_WHITE_BINARY,
    ACR_WHITE_FINE,
    ACR_MODE_RSVD
  } acr_mode_e;

  // Line counter states
  typedef enum logic [1:0] {
    ACR_IDLE,
    ACR_RUN,
    ACR_FOREVER
  } acr_cal_state_e;

  // Decoded black loop settings handed to the calibration engine
  typedef struct packed {
    logic [1:0]  dstep_shift;   // Digital step right shift
    logic [1:0]  astep_shift;   // Analog step right shift
    logic [5:0]  black_pixels;  // Pixels averaged
    logic [15:0] black_target;  // Target at 16-bit scale
  } acr_black_cfg_s;

endpackage : acr_pkg

`default_nettype wire

// *** logic/acr_step_scale.sv ***
// Step scaler: divides an offset correction step by a power of two.
// Assumes the shift code is stable for the cycle it is sampled.
`default_nettype none

module acr_step_scale
  import acr_pkg::*;
#(
  parameter int STEP_W = 10
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [STEP_W-1:0] step_in,
  input  wire logic [1:0]        shift,
  output logic      [STEP_W-1:0] step_out
);

  // Registered so the engine sees a clean value one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_out <= '0;
    end else begin
      step_out <= step_in >> shift;
    end
  end

  // Scaled step follows the input by exactly one cycle; the edge that
  // releases reset still loads zero, so the check waits one more edge
  step_shift_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> step_out == ($past(step_in) >> $past(shift)))
    else $error("step scaling mismatch");

endmodule : acr_step_scale

`default_nettype wire

// *** logic/acr_cal_regs.sv ***
// Calibration configuration register bank with APB slave access,
// decoded settings, the calibration line counter and the digital
// offset correction path.
// Assumes APB master holds the request until pready and one clock.
//
// Decided for this implementation: register access over APB.
`default_nettype none

module acr_cal_regs
  import acr_pkg::*;
#(
  parameter int OFS_W  = 13,   // Signed digital offset width
  parameter int STEP_W = 10    // Offset step width
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [6:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       sample_in,
  input  wire logic [OFS_W-1:0]  dig_offset_in,
  output logic      [15:0]       sample_out,
  input  wire logic              cal_start,
  input  wire logic              cal_stop,
  input  wire logic              line_start,
  output logic                   cal_active,
  output acr_mode_e              cal_mode,
  output acr_black_cfg_s         black_cfg,
  input  wire logic [STEP_W-1:0] dstep_in,
  output logic      [STEP_W-1:0] dstep_out,
  input  wire logic [STEP_W-1:0] astep_in,
  output logic      [STEP_W-1:0] astep_out
);

  // Stored registers
  logic [7:0]     cal_mode_ctrl;       // Mode and bypass
  logic [7:0]     cal_line_count;      // Lines to calibrate
  logic [7:0]     black_loop_config;   // Step scaling and pixel count
  logic [7:0]     black_level_target;  // Black goal, 11-bit scale
  logic [3:0]     page_sel;            // Current register page

  // Line counter state
  acr_cal_state_e state;               // Counter state
  logic [7:0]     lines_left;          // Lines still to run

  // Bus decode
  logic [4:0]     idx;                 // Word index of the access
  logic           on_cal_page;         // Page 2 selected
  logic           hit;                 // Address is mapped
  logic           access;              // Access phase
  logic           wr_en;               // Write takes effect now
  logic           digital_offset_bypass;

  // Zero wait states keep the slave simple; every access ends at once
  assign pready = 1'b1;
  assign idx    = paddr[6:2];
  assign access = psel && penable;

  // Page gating: page 2 registers only answer with page 2 chosen
  assign on_cal_page = (page_sel == CAL_PAGE);

  // Mapped addresses; everything else answers with an error
  always_comb begin
    hit = 1'b0;
    if (idx == IDX_PAGE_SEL) begin
      hit = 1'b1;
    end else if (on_cal_page) begin
      case (idx)
        IDX_CAL_MODE, IDX_LINE_COUNT, IDX_BLACK_CFG, IDX_BLACK_TGT,
        IDX_CAL_STATUS: hit = 1'b1;
        default:        hit = 1'b0;
      endcase
    end
  end

  assign pslverr = access && !hit;
  assign wr_en   = access && pwrite && hit;

  // Page select register, reachable from every page
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_sel <= RST_PAGE_SEL;
    end else if (wr_en && idx == IDX_PAGE_SEL) begin
      page_sel <= pwdata[3:0];
    end
  end

  // Page 2 configuration registers; status index is read only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_mode_ctrl      <= RST_CAL_MODE;
      cal_line_count     <= RST_LINE_COUNT;
      black_loop_config  <= RST_BLACK_CFG;
      black_level_target <= RST_BLACK_TGT;
    end else if (wr_en && on_cal_page) begin
      case (idx)
        IDX_CAL_MODE: begin
          // Upper bits are unused and kept at zero
          cal_mode_ctrl <= {5'h00, pwdata[2:0]};
        end
        IDX_LINE_COUNT: begin
          cal_line_count <= pwdata[7:0];
        end
        IDX_BLACK_CFG: begin
          // Bits 7:6 are unused
          black_loop_config <= {2'h0, pwdata[5:0]};
        end
        IDX_BLACK_TGT: begin
          black_level_target <= pwdata[7:0];
        end
        default: begin
          // Writes elsewhere are ignored
        end
      endcase
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop;
  // status may therefore be one cycle old when the access completes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (idx == IDX_PAGE_SEL) begin
        prdata[3:0] <= page_sel;
      end else if (on_cal_page) begin
        case (idx)
          IDX_CAL_MODE:   prdata[7:0] <= cal_mode_ctrl;
          IDX_LINE_COUNT: prdata[7:0] <= cal_line_count;
          IDX_BLACK_CFG:  prdata[7:0] <= black_loop_config;
          IDX_BLACK_TGT:  prdata[7:0] <= black_level_target;
          IDX_CAL_STATUS: prdata[8:0] <= {cal_active, lines_left};
          default:        prdata[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // Decoded settings
  assign digital_offset_bypass = cal_mode_ctrl[BYPASS_BIT];
  assign cal_mode = acr_mode_e'(cal_mode_ctrl[MODE_LSB +: 2]);

  // Step shifts: digital 00 is unity; analog 00 is reserved, no scaling
  assign black_cfg.dstep_shift = black_loop_config[DSTEP_LSB +: 2];
  assign black_cfg.astep_shift = black_loop_config[ASTEP_LSB +: 2];
  // Averaging window 4 << code
  assign black_cfg.black_pixels =
    PIX_BASE << black_loop_config[NPIX_LSB +: 2];
  // 16-bit scale target: 64 gives 2048, 255 gives 8160
  assign black_cfg.black_target =
    {8'h00, black_level_target} << TARGET_SHIFT;

  // Line counter: runs for the programmed number of lines, or forever
  // at 255; a zero count is reserved and simply does not start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ACR_IDLE;
      lines_left <= 8'h00;
    end else begin
      case (state)
        ACR_IDLE: begin
          if (cal_start && cal_line_count != LINES_RESERVED) begin
            lines_left <= cal_line_count;
            if (cal_line_count == LINES_FOREVER) begin
              state <= ACR_FOREVER;
            end else begin
              state <= ACR_RUN;
            end
          end
        end
        ACR_RUN: begin
          if (cal_stop) begin
            state      <= ACR_IDLE;
            lines_left <= 8'h00;
          end else if (line_start) begin
            lines_left <= lines_left - 8'h01;
            if (lines_left == 8'h01) begin
              state <= ACR_IDLE;
            end
          end
        end
        ACR_FOREVER: begin
          // Only an explicit stop ends endless calibration
          if (cal_stop) begin
            state      <= ACR_IDLE;
            lines_left <= 8'h00;
          end
        end
        default: begin
          state      <= ACR_IDLE;
          lines_left <= 8'h00;
        end
      endcase
    end
  end

  assign cal_active = (state != ACR_IDLE);

  // Output path with optional digital offset; the sum saturates so a
  // negative offset cannot wrap a dark pixel to full scale
  logic signed [17:0] corr_sum;
  assign corr_sum = $signed({2'b00, sample_in})
                  + 18'(signed'(dig_offset_in));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_out <= 16'h0000;
    end else if (digital_offset_bypass) begin
      sample_out <= sample_in;
    end else if (corr_sum < 18'sh00000) begin
      sample_out <= 16'h0000;
    end else if (corr_sum > 18'sh0FFFF) begin
      sample_out <= 16'hFFFF;
    end else begin
      sample_out <= corr_sum[15:0];
    end
  end

  // Step scalers for both offset DACs
  acr_step_scale #(.STEP_W(STEP_W)) u_dstep (
    .clk      (clk),
    .rst_b    (rst_b),
    .step_in  (dstep_in),
    .shift    (black_cfg.dstep_shift),
    .step_out (dstep_out)
  );

  acr_step_scale #(.STEP_W(STEP_W)) u_astep (
    .clk      (clk),
    .rst_b    (rst_b),
    .step_in  (astep_in),
    .shift    (black_cfg.astep_shift),
    .step_out (astep_out)
  );

  // Both output path checks start only once reset was sampled high: at
  // the releasing edge the flop still took its reset branch, so the
  // next cycle would otherwise be compared against a live sum
  // Bypassed output equals the raw sample one cycle later
  bypass_path_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (rst_b && digital_offset_bypass)
    |=> sample_out == $past(sample_in))
    else $error("bypass did not pass raw sample");

  // Corrected output in range carries the offset sum
  offset_path_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (rst_b && !digital_offset_bypass
     && corr_sum >= 0 && corr_sum <= 18'sh0FFFF)
    |=> sample_out == $past(corr_sum[15:0]))
    else $error("offset correction missing");

  // Mode write on page 2 shows on the mode output next cycle
  mode_write_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_en && on_cal_page && idx == IDX_CAL_MODE)
    |=> cal_mode == acr_mode_e'($past(pwdata[1:0])))
    else $error("mode field not applied");

  // Last counted line ends calibration
  line_end_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == ACR_RUN && line_start && !cal_stop && lines_left == 8'h01)
    |=> !cal_active)
    else $error("calibration overran its lines");

  // Accepted start loads the programmed count and raises activity
  start_count_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == ACR_IDLE && cal_start && cal_line_count != LINES_RESERVED)
    |=> cal_active && lines_left == $past(cal_line_count))
    else $error("calibration start not loaded");

  // Endless calibration survives lines without a stop
  forever_run_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == ACR_IDLE && cal_start && cal_line_count == LINES_FOREVER)
    ##1 (!cal_stop) [*3] |-> cal_active)
    else $error("endless calibration stopped");

  // Pixel window doubles with each code step
  pixel_count_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_en && on_cal_page && idx == IDX_BLACK_CFG)
    |=> black_cfg.black_pixels == (6'h04 << $past(pwdata[1:0])))
    else $error("black pixel count wrong");

  // Target scaling to 16-bit output level
  target_scale_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_en && on_cal_page && idx == IDX_BLACK_TGT)
    |=> black_cfg.black_target == {3'h0, $past(pwdata[7:0]), 5'h00})
    else $error("black target scale wrong");

  // Writes on another page leave the mode and black target registers alone
  page_gate_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    (access && pwrite && !on_cal_page && idx != IDX_PAGE_SEL)
    |=> $stable(cal_mode_ctrl) && $stable(black_level_target))
    else $error("write leaked through page gate");

endmodule : acr_cal_regs

`default_nettype wire

// *** tb/acr_cal_regs_tb.sv ***
// Self-checking bench for the calibration configuration register bank.
// Assumes an APB slave with any wait states and one 10 MHz clock; the
// bench drives
// every port itself, with no separate partner model.
`default_nettype none

module acr_cal_regs_tb;
  import acr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk;            // 10 MHz system clock
  logic            rst_b;          // Async reset, active low
  logic            psel;           // APB select
  logic            penable;        // APB access phase
  logic            pwrite;         // APB direction
  logic [6:0]      paddr;          // APB byte address
  logic [31:0]     pwdata;         // APB write data
  logic [31:0]     prdata;         // APB read data
  logic            pready;         // APB ready
  logic            pslverr;        // APB error
  logic [15:0]     sample_in;      // Raw sample
  logic [12:0]     dig_offset_in;  // Signed digital offset
  logic [15:0]     sample_out;     // Corrected sample
  logic            cal_start;      // Start pulse
  logic            cal_stop;       // Stop pulse
  logic            line_start;     // Line pulse
  logic            cal_active;     // Calibration running
  acr_mode_e       cal_mode;       // Decoded mode
  acr_black_cfg_s  black_cfg;      // Decoded black loop settings
  logic [9:0]      dstep_in;       // Digital step in
  logic [9:0]      dstep_out;      // Digital step scaled
  logic [9:0]      astep_in;       // Analog step in
  logic [9:0]      astep_out;      // Analog step scaled
  int              n_fail;         // Mismatches seen
  int              n_checks;       // Comparisons made
  logic [31:0]     rdv;            // Last read data
  logic            rerr;           // Last error flag

  acr_cal_regs acr_cal_regs_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .dig_offset_in(dig_offset_in), .sample_out(sample_out),
    .cal_start(cal_start), .cal_stop(cal_stop), .line_start(line_start),
    .cal_active(cal_active), .cal_mode(cal_mode), .black_cfg(black_cfg),
    .dstep_in(dstep_in), .dstep_out(dstep_out), .astep_in(astep_in),
    .astep_out(astep_out)
  );

  // Free-running clock, 100 ns period
  always #50 clk = ~clk;

  // Compare one value; case inequality so unknowns never match
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [6:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog may end a real hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read a register and compare data and error response
  task automatic rd(input logic [6:0] a, input logic [31:0] exp,
                    input logic eexp);
    apb(1'b0, a, 32'h0);
    check("prdata", rdv, exp);
    check("pslverr", {31'h0, rerr}, {31'h0, eexp});
  endtask : rd

  // Advance n edges, then let that edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Pulse one control input for a single cycle
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) cal_start <= 1'b1;
    else if (which == 1) line_start <= 1'b1;
    else cal_stop <= 1'b1;
    @(posedge clk);
    cal_start  <= 1'b0;
    line_start <= 1'b0;
    cal_stop   <= 1'b0;
    #1;
  endtask : pulse

  // Verdict and end of run; the only place the run stops
  task automatic finish_test;
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  // Main sequence
  initial begin
    clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 7'h00; pwdata = 32'h0;
    sample_in = 16'h1000; dig_offset_in = 13'h0010;
    cal_start = 1'b0; cal_stop = 1'b0; line_start = 1'b0;
    dstep_in = 10'h200; astep_in = 10'h100;
    n_fail = 0; n_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Page 0 selected after reset, so page-2 indices are refused
    rd({IDX_CAL_MODE, 2'b00}, 32'h0, 1'b1);
    // Write on the wrong page is refused; target must keep its reset
    apb(1'b1, {IDX_BLACK_TGT, 2'b00}, 32'h11);
    check("werr", {31'h0, rerr}, 32'h1);
    apb(1'b1, {IDX_PAGE_SEL, 2'b00}, {28'h0, CAL_PAGE});
    // Reset values
    rd({IDX_CAL_MODE, 2'b00}, 32'h00, 1'b0);
    rd({IDX_LINE_COUNT, 2'b00}, 32'h00, 1'b0);
    rd({IDX_BLACK_CFG, 2'b00}, 32'h14, 1'b0);
    rd({IDX_BLACK_TGT, 2'b00}, 32'h40, 1'b0);
    check("bcfg", black_cfg, {2'h1, 2'h1, 6'h04, 16'h0800});
    // Unmapped index answers with an error and zero data
    rd(7'h40, 32'h0, 1'b1);
    // Every defined mode code reaches the decode
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, {IDX_CAL_MODE, 2'b00}, m);
      rd({IDX_CAL_MODE, 2'b00}, m, 1'b0);
      check("mode", cal_mode, m);
    end
    // Bypass set: offset correction is dropped
    apb(1'b1, {IDX_CAL_MODE, 2'b00}, 32'h4);
    tick(2);
    check("sbyp", sample_out, 32'h1000);
    apb(1'b1, {IDX_CAL_MODE, 2'b00}, 32'h0);
    tick(2);
    check("sofs", sample_out, 32'h1010);
    // Negative offset below zero saturates at the bottom
    @(posedge clk);
    sample_in <= 16'h0008;
    dig_offset_in <= 13'h1FF0;
    tick(2);
    check("ssat", sample_out, 32'h0);
    // All step scale and pixel count codes; analog 00 means unity
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, {IDX_BLACK_CFG, 2'b00}, {26'h0, c[1:0], c[1:0], c[1:0]});
      tick(2);
      check("dstep", dstep_out, 10'h200 >> c);
      check("astep", astep_out, 10'h100 >> c);
      check("npix", black_cfg.black_pixels, 6'h04 << c);
    end
    // Top of the target range at output scale
    apb(1'b1, {IDX_BLACK_TGT, 2'b00}, 32'hFF);
    tick(1);
    check("tgt", black_cfg.black_target, 32'h1FE0);
    // Three lines: active until the third line pulse
    apb(1'b1, {IDX_LINE_COUNT, 2'b00}, 32'h3);
    pulse(0);
    check("act", cal_active, 1'b1);
    for (int i = 0; i < 3; i++) begin
      pulse(1);
      check("actn", cal_active, i < 2);
    end
    // 255 lines runs on until stopped
    apb(1'b1, {IDX_LINE_COUNT, 2'b00}, 32'hFF);
    pulse(0);
    for (int i = 0; i < 4; i++) begin
      pulse(1);
      check("actf", cal_active, 1'b1);
    end
    // Status shows the endless run with its count untouched
    rd({IDX_CAL_STATUS, 2'b00}, 32'h1FF, 1'b0);
    pulse(2);
    check("stop", cal_active, 1'b0);
    finish_test();
  end

endmodule : acr_cal_regs_tb

`default_nettype wire
